// ### core/feepa_dev.sv
`timescale 1ns/10ps
// Overview of operation
// - 64k-bit byte memory over serial link
// - Only upper quarter can be guarded
// - Guarded quarter starts at 6144
// - Seated line low blocks guarded writes unless unlock is high
// - Host prefers software unlock command
// - 32-byte pages, start address then data
// - Address advances after each data byte
// - Beyond 32 bytes wrap to first address
// - Host sends at most 32 data bytes
// - Six-byte hardware revision at 0x1816
// - 158-byte customer field at 0x1862
// - Coefficient record: two MSB-first words, exponent
// - Vout record 0x1900, Vin record 0x1919
// - Default address xxxx000 for 15 seconds
// - Host waits 15 seconds after reseating
// - Checksum is 0xFF minus identity sum
// - Outside identity reads 0xFF, gaps zero
module feepa_dev #(
    parameter longint unsigned SETTLE_CYC = feepa_pkg::SETTLE_CYC,
    parameter logic [6:0]      CFG_ADDR   = 7'h5b,   // Arbitrary example
    parameter logic [7:0]      HW_REV_CH  = 8'h41    // Arbitrary example
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    feepa_if.dev      lnk
);
    initial begin
        if (SETTLE_CYC < 1) $error("settle count must be positive");
    end
    // ==========================================================
    // Storage
    logic [7:0]  mem [feepa_pkg::MEM_BYTES];
    logic [12:0] base_r;                           // First written address
    logic [4:0]  offs_r;                           // Offset within burst
    logic [12:0] rptr_r;                           // Read pointer
    logic        ack_r;                            // Answer strobe register
    logic [7:0]  rdat_r;                           // Read data register
    logic        busy_r;                           // Address still settling
    logic [6:0]  addr_r;                           // Current bus address
    logic [63:0] settle_r;                         // Settle interval counter
    logic [2:0]  seat_sy_r;                        // Seated synchroniser
    logic        seat_r;                           // Filtered seated level
    // ==========================================================
    // Decode
    // Write address keeps the page bits of the first address and
    // lets only the low five bits run, so an overlong burst folds
    // back onto its own first byte instead of spilling over.
    wire logic [12:0] waddr   = {base_r[12:5], base_r[4:0] + offs_r};
    wire logic        guarded = waddr >= feepa_pkg::GUARD_BASE;
    wire logic        allow   = !guarded || seat_r || lnk.unlock;
    wire logic        is_wr   = lnk.req && lnk.op == feepa_pkg::OP_DATA;
    wire logic        is_st   = lnk.req && lnk.op == feepa_pkg::OP_START;
    wire logic        is_rd   = lnk.req && lnk.op == feepa_pkg::OP_READ;
    // ==========================================================
    // Factory image, built at elaboration
    // Outside the identity area every byte reads erased; inside it
    // unnamed places read zero. Fields that vary between units get
    // a fixed filler here, which a test may read but not rely on.
    function automatic logic [7:0] image(input int a);
        logic [7:0] v;
        v = feepa_pkg::FILL_BYTE;
        if (a < int'(feepa_pkg::GUARD_BASE) || a > int'(feepa_pkg::IDENT_LAST))
            v = feepa_pkg::ERASED_BYTE;
        else if (a >= int'(feepa_pkg::HW_REV_ADDR) &&
                 a < int'(feepa_pkg::HW_REV_ADDR) + feepa_pkg::HW_REV_LEN)
            v = HW_REV_CH;
        else if (a >= int'(feepa_pkg::CUST_ADDR) &&
                 a < int'(feepa_pkg::CUST_ADDR) + feepa_pkg::CUST_LEN)
            v = feepa_pkg::FILL_BYTE;
        else if (a == int'(feepa_pkg::COEF_VOUT_ADDR) + 1 ||
                 a == int'(feepa_pkg::COEF_VIN_ADDR) + 1)
            v = 8'h01;                                                // M=1 MSB first
        return v;
    endfunction
    // Checksum over the identity area, serial field and the sum
    // byte itself left out so that the sum stays fixed per image
    function automatic logic [7:0] chksum();
        logic [7:0] s;
        s = 8'h00;
        for (int a = int'(feepa_pkg::GUARD_BASE); a <= int'(feepa_pkg::IDENT_LAST); a++) begin
            if (!(a >= int'(feepa_pkg::SERIAL_ADDR) &&
                  a < int'(feepa_pkg::SERIAL_ADDR) + feepa_pkg::SERIAL_LEN) &&
                a != int'(feepa_pkg::CHKSUM_ADDR))
                s = s + image(a);
        end
        return 8'hff - s;
    endfunction
    // Load the factory image once; the array has no reset, so the
    // contents survive a reset of the control logic
    initial begin
        for (int a = 0; a < feepa_pkg::MEM_BYTES; a++) begin
            mem[a] = image(a);
        end
        mem[feepa_pkg::CHKSUM_ADDR] = chksum();
    end
    // ==========================================================
    // Memory write port
    // Plain clocked process: the array also takes its image from the
    // initial block above, which a strict always_ff would refuse.
    // A refused guarded write still gets its answer strobe, only the
    // store is suppressed here.
    always @(posedge i_clk) begin
        if (is_wr && allow) begin
            mem[waddr] <= lnk.wdat[7:0];
        end
    end
    // ==========================================================
    // Burst pointer and read port
    // A start loads both the burst base and the read pointer; data
    // advances only the burst offset, reads only the read pointer.
    // Every request is answered one cycle later, stored or not.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            base_r <= 13'h0000;
            offs_r <= 5'h00;
            rptr_r <= 13'h0000;
            ack_r  <= 1'b0;
            rdat_r <= 8'h00;
        end else begin
            ack_r <= lnk.req;
            if (is_st) begin
                base_r <= lnk.wdat[12:0];
                offs_r <= 5'h00;
                rptr_r <= lnk.wdat[12:0];
            end else if (is_wr) begin
                offs_r <= offs_r + 5'h01;
            end else if (is_rd) begin
                rdat_r <= mem[rptr_r];
                rptr_r <= rptr_r + 13'h0001;
            end
        end
    end
    // ==========================================================
    // Seated line synchroniser
    // Three stages; the filtered level only follows once the last
    // two stages agree, so a single glitch never opens the guard.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            seat_sy_r <= 3'h0;
            seat_r    <= 1'b0;
        end else begin
            seat_sy_r <= {seat_sy_r[1:0], lnk.seated};
            if (seat_sy_r[1] == seat_sy_r[2]) begin
                seat_r <= seat_sy_r[2];
            end
        end
    end
    // ==========================================================
    // Address settle after insertion
    // Default address with low bits zero until the interval counts
    // out, then the configured address; restarts only on reset.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            settle_r <= 64'h0;
            busy_r   <= 1'b1;
            addr_r   <= feepa_pkg::DEFAULT_ADDR;
        end else if (busy_r) begin
            if (settle_r == SETTLE_CYC - 1) begin
                busy_r <= 1'b0;
                addr_r <= CFG_ADDR;
            end else begin
                settle_r <= settle_r + 64'h1;
            end
        end
    end
    // ==========================================================
    // Link outputs, all straight from registers
    assign lnk.ack      = ack_r;
    assign lnk.rdat     = rdat_r;
    assign lnk.busy     = busy_r;
    assign lnk.bus_addr = addr_r;
endmodule

// ### core/feepa_host.sv
`timescale 1ns/10ps
module feepa_host #(
    parameter longint unsigned SETTLE_CYC = feepa_pkg::SETTLE_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,      // User request strobe
    input  wire logic [1:0]  i_op,       // Request kind
    input  wire logic [15:0] i_wdat,     // Address or data
    input  wire logic        i_unlock,   // Software unlock level
    input  wire logic        i_seated,   // Seated line drive
    output logic             o_ack,      // Answer strobe
    output logic [7:0]       o_rdat,     // Read data
    output logic             o_ready,    // Link usable
    output logic             o_drop,     // Request refused strobe
    feepa_if.host            lnk
);
    initial begin
        if (SETTLE_CYC < 1) $error("settle count must be positive");
    end
    // ==========================================================
    // State
    logic        req_r;
    logic [1:0]  op_r;
    logic [15:0] wdat_r;
    logic [5:0]  cnt_r;      // Data bytes in burst
    logic [63:0] wait_r;     // Hold-off counter
    logic        ack_r;
    logic [7:0]  rdat_r;
    logic        drop_r;
    logic        unl_r;
    logic        seat_r;
    logic        ready_r;    // Hold-off over, registered
    wire logic   held    = wait_r != 64'h0;
    wire logic   full    = i_op == feepa_pkg::OP_DATA && cnt_r == 6'(feepa_pkg::PAGE_BYTES);
    wire logic   accept  = i_req && !held && !full;
    // ==========================================================
    // Request path
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req_r  <= 1'b0;
            op_r   <= 2'h0;
            wdat_r <= 16'h0000;
            cnt_r  <= 6'h00;
            drop_r <= 1'b0;
            unl_r  <= 1'b0;
            seat_r <= 1'b0;
            ack_r  <= 1'b0;
            rdat_r <= 8'h00;
        end else begin
            req_r  <= accept;
            op_r   <= i_op;
            wdat_r <= i_wdat;
            drop_r <= i_req && !accept;
            unl_r  <= i_unlock;
            seat_r <= i_seated;
            ack_r  <= lnk.ack;
            rdat_r <= lnk.rdat;
            if (accept && i_op == feepa_pkg::OP_START) begin
                cnt_r <= 6'h00;
            end else if (accept && i_op == feepa_pkg::OP_DATA) begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end
    // ==========================================================
    // Hold-off after reseating
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_r  <= SETTLE_CYC;
            ready_r <= 1'b0;
        end else begin
            ready_r <= wait_r <= 64'h1;
            if (held) begin
                wait_r <= wait_r - 64'h1;
            end
        end
    end
    assign lnk.req    = req_r;
    assign lnk.op     = op_r;
    assign lnk.wdat   = wdat_r;
    assign lnk.unlock = unl_r;
    assign lnk.seated = seat_r;
    assign o_ack      = ack_r;
    assign o_rdat     = rdat_r;
    assign o_drop     = drop_r;
    assign o_ready    = ready_r;
endmodule

// ### core/feepa_if.sv
`timescale 1ns/10ps
// ==========================================================
// Byte link between host controller and memory end
interface feepa_if;
    logic        req;       // Request strobe, one cycle
    logic [1:0]  op;        // Request kind
    logic [15:0] wdat;      // Start address or data (low byte)
    logic        unlock;    // Software write unlock level
    logic        seated;    // Slot-seated line, high permits writes
    logic        ack;       // Answer strobe
    logic [7:0]  rdat;      // Read data
    logic        busy;      // Device still settling address
    logic [6:0]  bus_addr;  // Current bus address
    modport dev  (input req, op, wdat, unlock, seated, output ack, rdat, busy, bus_addr);
    modport host (output req, op, wdat, unlock, seated, input ack, rdat, busy, bus_addr);
endinterface

// ### core/feepa_pkg.sv
package feepa_pkg;
    // ==========================================================
    // Memory geometry
    localparam int unsigned MEM_BYTES      = 8192;      // 64k bits
    localparam int unsigned ADDR_W         = 13;
    localparam int unsigned PAGE_BYTES     = 32;
    localparam int unsigned PAGE_W         = 5;
    localparam logic [12:0] GUARD_BASE     = 13'h1800;  // Upper quarter start
    localparam logic [12:0] IDENT_LAST     = 13'h19ff;  // Identity area end
    // ==========================================================
    // Identity area layout
    localparam logic [12:0] HW_REV_ADDR    = 13'h1816;
    localparam int unsigned HW_REV_LEN     = 6;
    localparam logic [12:0] SERIAL_ADDR    = 13'h1822;
    localparam int unsigned SERIAL_LEN     = 14;
    localparam logic [12:0] CUST_ADDR      = 13'h1862;
    localparam int unsigned CUST_LEN       = 158;
    localparam logic [12:0] COEF_VOUT_ADDR = 13'h1900;
    localparam logic [12:0] COEF_VIN_ADDR  = 13'h1919;
    localparam int unsigned COEF_LEN       = 5;
    localparam logic [12:0] CHKSUM_ADDR    = 13'h191e;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;
    localparam logic [7:0]  FILL_BYTE      = 8'h00;
    // ==========================================================
    // Hot insertion timing
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned SETTLE_SEC     = 15;
    localparam longint unsigned SETTLE_CYC = longint'(SETTLE_SEC) * longint'(CLK_HZ);
    localparam logic [6:0]  DEFAULT_ADDR   = 7'h50;     // Low three bits zero
    // ==========================================================
    // Link opcodes
    localparam logic [1:0]  OP_START       = 2'h1;      // Byte is address
    localparam logic [1:0]  OP_DATA        = 2'h2;      // Write data byte
    localparam logic [1:0]  OP_READ        = 2'h3;      // Read at pointer
endpackage

// ### test/feepa_link_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Link checker between host end and memory end
module feepa_link_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        req,
    input wire logic [1:0]  op,
    input wire logic [15:0] wdat,
    input wire logic        unlock,
    input wire logic        seated,
    input wire logic        ack,
    input wire logic [7:0]  rdat,
    input wire logic        busy,
    input wire logic [6:0]  bus_addr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic blank_r;   // Pointer last set into blank upper space
    logic blank_nxt; // Next value of blank flag
    // ==========================================================
    // Helper: a start above the identity area arms the blank check
    assign blank_nxt = (req && op == feepa_pkg::OP_START) ? (wdat[12:0] >= 13'h1a00) :
                       ((req && op == feepa_pkg::OP_DATA) ? 1'b0 : blank_r);
    always_ff @(posedge i_clk) begin
        blank_r <= i_rst ? 1'b0 : blank_nxt;
    end
    sequence s_blank_read;
        req && op == feepa_pkg::OP_READ && blank_r;
    endsequence
    sequence s_erased_answer;
        ack && rdat == feepa_pkg::ERASED_BYTE;
    endsequence
    // ==========================================================
    // Assertions
    AST_ACK_NEXT: assert property (req |=> ack)
        else $error("request not answered next cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(req))
        else $error("answer without request");
    AST_SETTLE_ADDR: assert property (busy |-> bus_addr == feepa_pkg::DEFAULT_ADDR)
        else $error("address not default while settling");
    AST_NO_TALK: assert property (busy |-> !req)
        else $error("request while settling");
    AST_SETTLE_ONCE: assert property (!busy |=> !busy)
        else $error("settle restarted without reset");
    AST_SETTLE_MIN: assert property ($fell(busy) |-> $past(busy, 8))
        else $error("settle interval too short");
    AST_RDAT_HOLD: assert property (!$stable(rdat) |-> ack && $past(op) == feepa_pkg::OP_READ)
        else $error("read data moved without read");
    AST_BLANK_READ: assert property (s_blank_read |=> s_erased_answer)
        else $error("blank location not erased value");
endmodule

// ### test/fru_eeprom_page_access_tb.sv
`timescale 1ns/10ps
module fru_eeprom_page_access_tb;
    logic             i_clk;
    logic             i_rst;
    logic             i_req;
    logic [1:0]       i_op;
    logic [15:0]      i_wdat;
    logic             i_unlock;
    logic             i_seated;
    logic             o_ack;
    logic [7:0]       o_rdat;
    logic             o_ready;
    logic             o_drop;
    logic [7:0]       got;       // Last answer seen
    logic [7:0]       old;       // Saved byte
    logic [7:0]       mdl [int]; // Byte model of written places
    int               fail_count;
    int               tests_run;
    int               seed;
    int               sum;
    int               n;
    feepa_if feepa_if_i ();
    feepa_dev #(.SETTLE_CYC(20), .CFG_ADDR(7'h2c), .HW_REV_CH(8'h41)) feepa_dev_i (
        .i_clk(i_clk), .i_rst(i_rst), .lnk(feepa_if_i));
    feepa_host #(.SETTLE_CYC(20)) feepa_host_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .i_op(i_op), .i_wdat(i_wdat), .i_unlock(i_unlock), .i_seated(i_seated), .o_ack(o_ack),
        .o_rdat(o_rdat), .o_ready(o_ready), .o_drop(o_drop), .lnk(feepa_if_i));
    feepa_link_monitor feepa_link_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .req(feepa_if_i.req),
        .op(feepa_if_i.op), .wdat(feepa_if_i.wdat), .unlock(feepa_if_i.unlock),
        .seated(feepa_if_i.seated), .ack(feepa_if_i.ack), .rdat(feepa_if_i.rdat),
        .busy(feepa_if_i.busy), .bus_addr(feepa_if_i.bus_addr));
    // ==========================================================
    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Compare one value and count it
    task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    // Verdict and end of run
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One request strobe, bounded wait for answer or refusal
    task xfer(input logic [1:0] op, input logic [15:0] d, input logic drop);
        int k;
        i_req = 1'b1;
        i_op = op;
        i_wdat = d;
        @(negedge i_clk);
        i_req = 1'b0;
        for (k = 0; k < 12 && o_ack !== 1'b1 && o_drop !== 1'b1; k++) begin
            @(negedge i_clk);
        end
        if (k == 12) begin
            $display("Error answer expected 1 seen 0");
            fail_count++;
            stop_test;
        end
        chk("refusal", {15'h0, drop}, {15'h0, o_drop});
        got = o_rdat;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        seed = 20660;
        {i_req, i_op, i_wdat, i_unlock, i_seated, fail_count, tests_run} = '0;
        i_rst = 1'b1;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        // Hold-off refusal, then configured address
        xfer(feepa_pkg::OP_START, 16'h0040, 1'b1);
        for (n = 0; n < 100 && o_ready !== 1'b1; n++) @(negedge i_clk);
        if (n == 100) begin
            $display("Error ready expected 1 seen 0");
            fail_count++;
            stop_test;
        end
        chk("bus address", 16'h002c, {9'h0, feepa_if_i.bus_addr});
        $display("test hold-off done");
        // Page write from offset 5, wraps inside the page
        xfer(feepa_pkg::OP_START, 16'h0045, 1'b0);
        for (n = 0; n < 32; n++) begin
            old = 8'($random(seed));
            mdl[32'h40 | ((5 + n) & 31)] = old;
            xfer(feepa_pkg::OP_DATA, {8'h0, old}, 1'b0);
        end
        xfer(feepa_pkg::OP_DATA, 16'h00a5, 1'b1);
        xfer(feepa_pkg::OP_START, 16'h0040, 1'b0);
        for (n = 0; n < 33; n++) begin
            xfer(feepa_pkg::OP_READ, 16'h0, 1'b0);
            chk("page byte", {8'h0, (n < 32) ? mdl[32'h40 + n] : 8'hff}, {8'h0, got});
        end
        $display("test page wrap done");
        // Identity checksum over the identity area
        xfer(feepa_pkg::OP_START, 16'h1800, 1'b0);
        sum = 0;
        for (n = 0; n < 512; n++) begin
            xfer(feepa_pkg::OP_READ, 16'h0, 1'b0);
            if (n == 'h11e) old = got;
            else if (n < 'h22 || n >= 'h30) sum += got;
        end
        chk("checksum", {8'h0, 8'(8'hff - sum[7:0])}, {8'h0, old});
        xfer(feepa_pkg::OP_START, 16'h1a00, 1'b0);
        xfer(feepa_pkg::OP_READ, 16'h0, 1'b0);
        chk("blank byte", 16'h00ff, {8'h0, got});
        $display("test identity done");
        // Guard: locked, seated, unlocked, lower area
        for (n = 0; n < 4; n++) begin
            i_seated = (n == 1);
            i_unlock = (n == 2);
            repeat (5) @(negedge i_clk);
            i_wdat = (n == 3) ? 16'h0100 : 16'h1900;
            xfer(feepa_pkg::OP_START, i_wdat, 1'b0);
            xfer(feepa_pkg::OP_READ, 16'h0, 1'b0);
            old = got;
            xfer(feepa_pkg::OP_START, (n == 3) ? 16'h0100 : 16'h1900, 1'b0);
            xfer(feepa_pkg::OP_DATA, {8'h0, ~old}, 1'b0);
            xfer(feepa_pkg::OP_START, (n == 3) ? 16'h0100 : 16'h1900, 1'b0);
            xfer(feepa_pkg::OP_READ, 16'h0, 1'b0);
            chk("guard byte", {8'h0, (n == 0) ? old : ~old}, {8'h0, got});
        end
        $display("test guard done");
        stop_test;
    end
endmodule
